// ### design/uifc_cfg.svh
// offsets, field positions, reset values and trigger levels of the interrupt/fifo control block
// assumes a 32-bit APB slave port and 32-entry transmit and receive fifos outside this block
`ifndef UIFC_CFG_SVH
`define UIFC_CFG_SVH

`define UIFC_OFF_IER      12'h000
`define UIFC_OFF_ISR      12'h004
`define UIFC_OFF_FCR      12'h008
`define UIFC_OFF_EFR      12'h00C
`define UIFC_OFF_STAT     12'h010

`define UIFC_IER_RESET    8'h00
`define UIFC_EFR_BIT      4

`define UIFC_FCR_EN       0
`define UIFC_FCR_RXRST    1
`define UIFC_FCR_TXRST    2
`define UIFC_FCR_DMA      3
`define UIFC_FCR_TXSEL    5:4
`define UIFC_FCR_RXSEL    7:6

`define UIFC_ID_LS        6'h06
`define UIFC_ID_TMO       6'h0C
`define UIFC_ID_RXD       6'h04
`define UIFC_ID_TXR       6'h02
`define UIFC_ID_MS        6'h00
`define UIFC_ID_XOFF      6'h10
`define UIFC_ID_FLOW      6'h20
`define UIFC_ID_NONE      6'h01

`define UIFC_RX_TRIG0     6'h08
`define UIFC_RX_TRIG1     6'h10
`define UIFC_RX_TRIG2     6'h18
`define UIFC_RX_TRIG3     6'h1C
`define UIFC_TX_TRIG0     6'h10
`define UIFC_TX_TRIG1     6'h08
`define UIFC_TX_TRIG2     6'h18
`define UIFC_TX_TRIG3     6'h1E
`define UIFC_FIFO_DEPTH   6'h20

`define UIFC_TMO_EXTRA    7'h0C

`endif

// ### design/uifc_pkg.sv
// types shared by the interrupt/fifo control block
// assumes nothing beyond the compile order
package uifc_pkg;
	typedef logic [7:0]  uifc_byte_t;
	typedef logic [5:0]  uifc_count_t;
	typedef logic [5:0]  uifc_id_t;
	typedef logic [6:0]  uifc_src_t;
endpackage

// ### design/uifc_prio.sv
// priority encoder from pending sources to the status code
// assumes req bit 0 is the highest level and bit 6 the lowest
`include "uifc_cfg.svh"
module uifc_prio (
	input  wire uifc_pkg::uifc_src_t req,
	output uifc_pkg::uifc_id_t       id,
	output uifc_pkg::uifc_src_t      grant
);
	import uifc_pkg::*;

	always_comb begin
		grant = 7'h00;
		id    = `UIFC_ID_NONE;
		if (req[0]) begin
			grant = 7'h01;
			id    = `UIFC_ID_LS;
		end else if (req[1]) begin
			grant = 7'h02;
			id    = `UIFC_ID_TMO;
		end else if (req[2]) begin
			grant = 7'h04;
			id    = `UIFC_ID_RXD;
		end else if (req[3]) begin
			grant = 7'h08;
			id    = `UIFC_ID_TXR;
		end else if (req[4]) begin
			grant = 7'h10;
			id    = `UIFC_ID_MS;
		end else if (req[5]) begin
			grant = 7'h20;
			id    = `UIFC_ID_XOFF;
		end else if (req[6]) begin
			grant = 7'h40;
			id    = `UIFC_ID_FLOW;
		end
	end
endmodule

// ### design/uifc_top.sv
// interrupt enable, interrupt status and fifo control of one uart channel
// assumes the fifos, shifters and flow control sit outside on the same clock;
// only the clear-to-send pin arrives from outside and is synchronised here
//
// Design decisions made here: the APB register port and the register offsets.
`include "uifc_cfg.svh"
module uifc_top (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire uifc_pkg::uifc_count_t rx_count,
	input  wire uifc_pkg::uifc_count_t tx_count,
	input  wire logic [3:0]          line_status_err,
	input  wire logic [3:0]          modem_status_delta,
	input  wire logic                rhr_read,
	input  wire logic                lsr_read,
	input  wire logic                msr_read,
	input  wire logic                thr_write,
	input  wire logic                rx_char_push,
	input  wire logic                xoff_rcvd,
	input  wire logic                xon_rcvd,
	input  wire logic                special_rcvd,
	input  wire logic                bit_tick,
	input  wire logic [3:0]          char_bits,
	input  wire logic                auto_rts_en,
	input  wire logic                auto_cts_en,
	input  wire logic                rts_n,
	input  wire logic                cts_n,
	output logic                     irq,
	output logic                     fifo_enable,
	output logic                     dma_mode,
	output logic                     sleep_enable,
	output logic                     rx_fifo_reset,
	output logic                     tx_fifo_reset,
	output uifc_pkg::uifc_count_t    rx_trigger,
	output uifc_pkg::uifc_count_t    tx_trigger,
	output logic                     receive_ready_pin_n,
	output logic                     transmit_ready_pin_n
);
	import uifc_pkg::*;

	uifc_byte_t  interrupt_enable;
	uifc_byte_t  next_ier;
	logic        efr_en;
	logic        next_efr_en;
	logic        next_fifo_enable;
	logic        next_dma_mode;
	logic [1:0]  tx_sel;
	logic [1:0]  next_tx_sel;
	logic [1:0]  rx_sel;
	logic [1:0]  next_rx_sel;
	uifc_count_t next_rx_trigger;
	uifc_count_t next_tx_trigger;
	logic        next_rx_fifo_reset;
	logic        next_tx_fifo_reset;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	uifc_src_t   rd_grant;
	uifc_src_t   next_rd_grant;
	logic        ls_pend, tmo_pend, tx_pend, ms_pend, xoff_pend, spec_pend, rts_pend, cts_pend;
	logic        next_ls_pend, next_tmo_pend, next_tx_pend, next_ms_pend;
	logic        next_xoff_pend, next_spec_pend, next_rts_pend, next_cts_pend;
	logic        rts_prev, next_rts_prev;
	logic        cts_s1, cts_s2, cts_s3, cts_filt, next_cts_filt;
	logic        tx_above, next_tx_above;
	uifc_count_t tx_prev, next_tx_prev;
	logic        next_irq, next_rx_pin_n, next_tx_pin_n;
	logic [6:0]  tmo_cnt, next_tmo_cnt;
	logic [6:0]  tmo_limit;
	logic        tmo_hit;
	uifc_src_t   req;
	uifc_id_t    isr_id;
	uifc_src_t   grant;
	logic        hit, acc_load, acc_done, wr_ier, wr_fcr, wr_efr, rd_isr;
	logic        rx_lvl, tx_set, isr_clr_tx, isr_clr_xoff;
	logic        cts_rise, rts_rise;
	logic [31:0] rd_word;

	// bus decode
	assign hit = (paddr == `UIFC_OFF_IER) || (paddr == `UIFC_OFF_ISR) ||
		(paddr == `UIFC_OFF_FCR) || (paddr == `UIFC_OFF_EFR) || (paddr == `UIFC_OFF_STAT);
	assign acc_load = psel & penable & ~pready;
	assign acc_done = psel & penable & pready;
	assign wr_ier   = acc_done & pwrite & (paddr == `UIFC_OFF_IER);
	assign wr_fcr   = acc_done & pwrite & (paddr == `UIFC_OFF_FCR);
	assign wr_efr   = acc_done & pwrite & (paddr == `UIFC_OFF_EFR);
	assign rd_isr   = acc_done & ~pwrite & (paddr == `UIFC_OFF_ISR);

	always_comb begin
		unique case (paddr)
			`UIFC_OFF_IER:  rd_word = {24'h000000, interrupt_enable};
			`UIFC_OFF_ISR:  rd_word = {24'h000000, {2{fifo_enable}}, isr_id};
			`UIFC_OFF_EFR:  rd_word = {27'h0000000, efr_en, 4'h0};
			`UIFC_OFF_STAT: rd_word = {16'h0000, req, 2'h0, sleep_enable, rx_sel, tx_sel,
				dma_mode, fifo_enable};
			default:        rd_word = 32'h00000000; // write-only control reads zero
		endcase
	end

	// one wait state: data and the shown source are caught together so that the
	// side effect of a status read hits exactly the source that was returned
	always_comb begin
		next_pready   = acc_load;
		next_prdata   = prdata;
		next_pslverr  = pslverr;
		next_rd_grant = rd_grant;
		if (acc_load) begin
			next_prdata   = pwrite ? 32'h00000000 : rd_word;
			next_pslverr  = ~hit;
			next_rd_grant = grant;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			rd_grant <= 7'h00;
		end else begin
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			rd_grant <= next_rd_grant;
		end
	end

	// configuration registers
	always_comb begin
		next_ier           = interrupt_enable;
		next_efr_en        = efr_en;
		next_fifo_enable   = fifo_enable;
		next_dma_mode      = dma_mode;
		next_tx_sel        = tx_sel;
		next_rx_sel        = rx_sel;
		next_rx_fifo_reset = 1'b0;
		next_tx_fifo_reset = 1'b0;
		if (wr_ier) begin
			next_ier[3:0] = pwdata[3:0];
			if (efr_en)
				next_ier[7:4] = pwdata[7:4];
		end
		if (wr_efr)
			next_efr_en = pwdata[`UIFC_EFR_BIT];
		if (wr_fcr) begin
			next_fifo_enable = pwdata[`UIFC_FCR_EN];
			if (pwdata[`UIFC_FCR_EN]) begin
				next_rx_fifo_reset = pwdata[`UIFC_FCR_RXRST];
				next_tx_fifo_reset = pwdata[`UIFC_FCR_TXRST];
				next_dma_mode      = pwdata[`UIFC_FCR_DMA];
				next_rx_sel        = pwdata[`UIFC_FCR_RXSEL];
				if (efr_en)
					next_tx_sel = pwdata[`UIFC_FCR_TXSEL];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			interrupt_enable           <= `UIFC_IER_RESET;
			efr_en        <= 1'b0;
			fifo_enable   <= 1'b0;
			dma_mode      <= 1'b0;
			tx_sel        <= 2'h0;
			rx_sel        <= 2'h0;
			rx_fifo_reset <= 1'b0;
			tx_fifo_reset <= 1'b0;
			rx_trigger    <= `UIFC_RX_TRIG0;
			tx_trigger    <= `UIFC_TX_TRIG0;
		end else begin
			interrupt_enable           <= next_ier;
			efr_en        <= next_efr_en;
			fifo_enable   <= next_fifo_enable;
			dma_mode      <= next_dma_mode;
			tx_sel        <= next_tx_sel;
			rx_sel        <= next_rx_sel;
			rx_fifo_reset <= next_rx_fifo_reset;
			tx_fifo_reset <= next_tx_fifo_reset;
			rx_trigger    <= next_rx_trigger;
			tx_trigger    <= next_tx_trigger;
		end
	end

	always_comb begin
		// decoded from the next select so the registered trigger tracks the select
		unique case (next_rx_sel)
			2'h0: next_rx_trigger = `UIFC_RX_TRIG0;
			2'h1: next_rx_trigger = `UIFC_RX_TRIG1;
			2'h2: next_rx_trigger = `UIFC_RX_TRIG2;
			2'h3: next_rx_trigger = `UIFC_RX_TRIG3;
		endcase
		unique case (next_tx_sel)
			2'h0: next_tx_trigger = `UIFC_TX_TRIG0;
			2'h1: next_tx_trigger = `UIFC_TX_TRIG1;
			2'h2: next_tx_trigger = `UIFC_TX_TRIG2;
			2'h3: next_tx_trigger = `UIFC_TX_TRIG3;
		endcase
	end
	assign sleep_enable = interrupt_enable[4];

	// receive timeout timer, counted in bit times; restarts on a receive fifo push or read
	assign tmo_limit = {1'b0, char_bits, 2'b00} + `UIFC_TMO_EXTRA;
	// fires on the tick that completes the full delay, not one tick later
	assign tmo_hit   = bit_tick & (tmo_cnt == tmo_limit - 7'h01) & (rx_count != 6'h00);
	always_comb begin
		next_tmo_cnt = tmo_cnt;
		if (rx_char_push || rhr_read || rx_count == 6'h00 || !fifo_enable)
			next_tmo_cnt = 7'h00;
		else if (bit_tick && tmo_cnt != tmo_limit)
			next_tmo_cnt = tmo_cnt + 7'h01;
	end

	always_ff @(posedge clk) begin
		if (rst)
			tmo_cnt <= 7'h00;
		else
			tmo_cnt <= next_tmo_cnt;
	end

	// clear-to-send pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
			cts_s3 <= 1'b1;
		end else begin
			cts_s1 <= cts_n;
			cts_s2 <= cts_s1;
			cts_s3 <= cts_s2;
		end
	end
	assign next_cts_filt = (cts_s2 == cts_s3) ? cts_s3 : cts_filt;
	assign cts_rise      = next_cts_filt & ~cts_filt;
	assign next_rts_prev = rts_n;
	assign rts_rise      = rts_n & ~rts_prev;

	// level sources
	assign rx_lvl = fifo_enable ? (rx_count >= rx_trigger) : (rx_count != 6'h00);
	// transmit: fall below trigger after a reload above it, else only once empty
	always_comb begin
		uifc_count_t trig;
		trig          = fifo_enable ? tx_trigger : 6'h01;
		next_tx_prev  = tx_count;
		next_tx_above = tx_above;
		if (tx_count > trig)
			next_tx_above = 1'b1;
		else if (tx_count == 6'h00)
			next_tx_above = 1'b0;
		tx_set = (tx_above & (tx_prev >= trig) & (tx_count < trig)) |
			(~tx_above & (tx_prev != 6'h00) & (tx_count == 6'h00)) |
			(next_ier[1] & ~interrupt_enable[1] & (tx_count == 6'h00));
	end

	assign isr_clr_tx   = rd_isr & rd_grant[3];
	assign isr_clr_xoff = rd_isr & rd_grant[5];

	// sticky sources: a set in the cycle of a clear always wins
	always_comb begin
		next_ls_pend   = (|line_status_err) | (ls_pend & ~lsr_read);
		next_tmo_pend  = tmo_hit | (tmo_pend & ~rhr_read);
		next_tx_pend   = tx_set | (tx_pend & ~thr_write & ~isr_clr_tx);
		next_ms_pend   = (|modem_status_delta) | (ms_pend & ~msr_read);
		next_xoff_pend = xoff_rcvd | (xoff_pend & ~xon_rcvd & ~isr_clr_xoff);
		next_spec_pend = special_rcvd | (spec_pend & ~rx_char_push & ~isr_clr_xoff);
		next_rts_pend  = (rts_rise & auto_rts_en & interrupt_enable[6]) | (rts_pend & ~msr_read);
		next_cts_pend  = (cts_rise & auto_cts_en & interrupt_enable[7]) | (cts_pend & ~msr_read);
	end

	assign req[0] = ls_pend & interrupt_enable[2];
	assign req[1] = tmo_pend & interrupt_enable[0];
	assign req[2] = rx_lvl & interrupt_enable[0];
	assign req[3] = tx_pend & interrupt_enable[1];
	assign req[4] = ms_pend & interrupt_enable[3];
	assign req[5] = (xoff_pend | spec_pend) & interrupt_enable[5] & efr_en;
	assign req[6] = (rts_pend | cts_pend) & efr_en;

	uifc_prio u_prio (
		.req   (req),
		.id    (isr_id),
		.grant (grant)
	);

	assign next_irq      = |req;
	assign next_rx_pin_n = ~(dma_mode ? (rx_lvl | tmo_pend) : (rx_count != 6'h00));
	assign next_tx_pin_n = ~(dma_mode ? (tx_count < `UIFC_FIFO_DEPTH) : (tx_count == 6'h00));

	always_ff @(posedge clk) begin
		if (rst) begin
			ls_pend              <= 1'b0;
			tmo_pend             <= 1'b0;
			tx_pend              <= 1'b0;
			ms_pend              <= 1'b0;
			xoff_pend            <= 1'b0;
			spec_pend            <= 1'b0;
			rts_pend             <= 1'b0;
			cts_pend             <= 1'b0;
			rts_prev             <= 1'b1;
			cts_filt             <= 1'b1;
			tx_above             <= 1'b0;
			tx_prev              <= 6'h00;
			irq                  <= 1'b0;
			receive_ready_pin_n  <= 1'b1;
			transmit_ready_pin_n <= 1'b1;
		end else begin
			ls_pend              <= next_ls_pend;
			tmo_pend             <= next_tmo_pend;
			tx_pend              <= next_tx_pend;
			ms_pend              <= next_ms_pend;
			xoff_pend            <= next_xoff_pend;
			spec_pend            <= next_spec_pend;
			rts_pend             <= next_rts_pend;
			cts_pend             <= next_cts_pend;
			rts_prev             <= next_rts_prev;
			cts_filt             <= next_cts_filt;
			tx_above             <= next_tx_above;
			tx_prev              <= next_tx_prev;
			irq                  <= next_irq;
			receive_ready_pin_n  <= next_rx_pin_n;
			transmit_ready_pin_n <= next_tx_pin_n;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_ier_reset;
		$past(rst) |-> (interrupt_enable == 8'h00 && !sleep_enable);
	endproperty
	a_ier_reset: assert property (p_ier_reset) else $error("enable not cleared by reset");

	property p_ier_locked;
		wr_ier && !efr_en |=> interrupt_enable[7:4] == $past(interrupt_enable[7:4]);
	endproperty
	a_ier_locked: assert property (p_ier_locked) else $error("upper enables changed");

	property p_idle_code;
		!(|req) |-> (isr_id == 6'h01) ##1 !irq;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle code or irq wrong");

	property p_isr_fifo_bits;
		acc_load && !pwrite && paddr == `UIFC_OFF_ISR |=> prdata[7:6] == {2{$past(fifo_enable)}};
	endproperty
	a_isr_fifo_bits: assert property (p_isr_fifo_bits) else $error("status bits 7:6 wrong");

	property p_fcr_ignored;
		wr_fcr && !pwdata[0] |=> !fifo_enable && dma_mode == $past(dma_mode) && !rx_fifo_reset;
	endproperty
	a_fcr_ignored: assert property (p_fcr_ignored) else $error("fifo control not ignored");

	property p_rx_reset_pulse;
		wr_fcr && pwdata[1:0] == 2'h3 |=> rx_fifo_reset ##1 !rx_fifo_reset;
	endproperty
	a_rx_reset_pulse: assert property (p_rx_reset_pulse) else $error("rx reset pulse wrong");

	property p_tx_clear;
		thr_write && !tx_set |=> !tx_pend;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("transmit ready not cleared");

	property p_tmo_clear;
		rhr_read && !tmo_hit |=> !tmo_pend;
	endproperty
	a_tmo_clear: assert property (p_tmo_clear) else $error("timeout not cleared");

	property p_cts_irq;
		cts_rise && auto_cts_en && interrupt_enable[7] && efr_en && !wr_efr |=> cts_pend ##1 irq;
	endproperty
	a_cts_irq: assert property (p_cts_irq) else $error("cts rise not raised");

	property p_ls_top;
		ls_pend && interrupt_enable[2] |-> isr_id == 6'h06;
	endproperty
	a_ls_top: assert property (p_ls_top) else $error("line status not top priority");
endmodule

// ### testbench/tb_uart_interrupt_fifo_control.sv
// self-checking bench of the interrupt/fifo control block
// assumes the host model for apb; uart-side events are driven here as pulses
module tb_uart_interrupt_fifo_control;
	timeunit 1ns;
	timeprecision 1ps;
	import uifc_pkg::*;
	`include "uifc_cfg.svh"
	logic clk = 1'b0, rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	uifc_count_t rx_count, tx_count, rx_trigger, tx_trigger;
	logic [3:0] line_status_err, modem_status_delta, char_bits;
	logic [7:0] ev;
	logic bit_tick, auto_rts_en, auto_cts_en, rts_n, cts_n;
	logic irq, fifo_enable, dma_mode, sleep_enable, rx_fifo_reset, tx_fifo_reset;
	logic receive_ready_pin_n, transmit_ready_pin_n;
	int error_cnt = 0, n_compared = 0, rxr_n = 0, txr_n = 0;
	uifc_count_t rxt [4] = '{6'h08, 6'h10, 6'h18, 6'h1C};
	uifc_count_t txt [4] = '{6'h10, 6'h08, 6'h18, 6'h1E};

	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (rx_fifo_reset === 1'b1) rxr_n++;
		if (tx_fifo_reset === 1'b1) txr_n++;
	end

	uifc_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	uifc_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_count(rx_count), .tx_count(tx_count), .line_status_err(line_status_err),
		.modem_status_delta(modem_status_delta), .rhr_read(ev[0]), .lsr_read(ev[1]),
		.msr_read(ev[2]), .thr_write(ev[3]), .rx_char_push(ev[4]), .xoff_rcvd(ev[5]),
		.xon_rcvd(ev[6]), .special_rcvd(ev[7]), .bit_tick(bit_tick), .char_bits(char_bits),
		.auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en), .rts_n(rts_n), .cts_n(cts_n),
		.irq(irq), .fifo_enable(fifo_enable), .dma_mode(dma_mode),
		.sleep_enable(sleep_enable), .rx_fifo_reset(rx_fifo_reset),
		.tx_fifo_reset(tx_fifo_reset), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
		.receive_ready_pin_n(receive_ready_pin_n),
		.transmit_ready_pin_n(transmit_ready_pin_n));

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(1'b1, a, d, r, last_err);
		if (host.hung === 1'b1) begin
			error_cnt++;
			finish_test();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		host.xfer(1'b0, a, 32'h0, r, last_err);
		if (host.hung === 1'b1) begin
			error_cnt++;
			finish_test();
		end else
			chk(r, exp);
	endtask

	// one-cycle event pulses, then time for pend and irq to follow
	task automatic pulse(input logic [7:0] m);
		@(posedge clk) ev <= m;
		@(posedge clk) ev <= 8'h00;
		repeat (4) @(posedge clk);
	endtask

	task automatic settle();
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk) bit_tick <= 1'b1;
			@(posedge clk) bit_tick <= 1'b0;
		end
	endtask

	initial begin
		rx_count = 6'h00;
		tx_count = 6'h00;
		line_status_err = 4'h0;
		modem_status_delta = 4'h0;
		char_bits = 4'h4;
		ev = 8'h00;
		bit_tick = 1'b0;
		{auto_rts_en, auto_cts_en, rts_n, cts_n} = 4'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(`UIFC_OFF_IER, 32'h00);
		rd(`UIFC_OFF_ISR, 32'h01);
		wr(`UIFC_OFF_IER, 32'hFF);
		rd(`UIFC_OFF_IER, 32'h0F);
		wr(`UIFC_OFF_IER, 32'h00);
		rd(`UIFC_OFF_FCR, 32'h00);
		rd(12'h020, 32'h00);
		chk(last_err, 1'b1);
		wr(`UIFC_OFF_EFR, 32'h10);
		wr(`UIFC_OFF_IER, 32'h10);
		@(negedge clk);
		chk(sleep_enable, 1'b1);
		wr(`UIFC_OFF_IER, 32'h00);
		tx_count <= 6'h05;
		for (int i = 0; i < 4; i++) begin
			host.fifo_control({i[1:0], i[1:0], 4'h8});
			settle();
			chk(rx_trigger, rxt[i]);
			chk(tx_trigger, txt[i]);
			chk(dma_mode, 1'b1);
			chk(transmit_ready_pin_n, 1'b0);
			rd(`UIFC_OFF_ISR, 32'hC1);
		end
		host.fifo_control(8'h00);
		settle();
		chk(dma_mode, 1'b0);
		chk(transmit_ready_pin_n, 1'b1);
		host.fifo_control(8'h02);
		host.fifo_control(8'h04);
		settle();
		chk(rxr_n, 1);
		chk(txr_n, 1);
		wr(`UIFC_OFF_FCR, 32'h06);
		settle();
		chk(fifo_enable, 1'b0);
		chk(rxr_n + txr_n, 2);
		rd(`UIFC_OFF_ISR, 32'h01);
		host.fifo_control(8'h00);
		tx_count <= 6'h00;
		wr(`UIFC_OFF_IER, 32'h04);
		line_status_err <= 4'h1;
		settle();
		chk(irq, 1'b1);
		@(posedge clk);
		rx_count <= 6'h08;
		wr(`UIFC_OFF_IER, 32'h05);
		rd(`UIFC_OFF_ISR, 32'hC6);
		line_status_err <= 4'h0;
		pulse(8'h02);
		rd(`UIFC_OFF_ISR, 32'hC4);
		rd(`UIFC_OFF_ISR, 32'hC4);
		rx_count <= 6'h07;
		settle();
		chk(irq, 1'b0);
		chk(receive_ready_pin_n, 1'b0);
		rd(`UIFC_OFF_ISR, 32'hC1);
		rx_count <= 6'h01;
		tick(27);
		rd(`UIFC_OFF_ISR, 32'hC1);
		tick(1);
		settle();
		rd(`UIFC_OFF_ISR, 32'hCC);
		pulse(8'h01);
		rd(`UIFC_OFF_ISR, 32'hC1);
		rx_count <= 6'h00;
		wr(`UIFC_OFF_IER, 32'h02);
		rd(`UIFC_OFF_ISR, 32'hC2);
		rd(`UIFC_OFF_ISR, 32'hC1);
		wr(`UIFC_OFF_IER, 32'h00);
		wr(`UIFC_OFF_IER, 32'h02);
		settle();
		chk(irq, 1'b1);
		pulse(8'h08);
		rd(`UIFC_OFF_ISR, 32'hC1);
		wr(`UIFC_OFF_IER, 32'hE8);
		modem_status_delta <= 4'h8;
		@(posedge clk) modem_status_delta <= 4'h0;
		settle();
		rd(`UIFC_OFF_ISR, 32'hC0);
		rd(`UIFC_OFF_ISR, 32'hC0);
		pulse(8'h04);
		rd(`UIFC_OFF_ISR, 32'hC1);
		pulse(8'h20);
		@(negedge clk);
		chk(irq, 1'b1);
		pulse(8'h40);
		@(negedge clk);
		chk(irq, 1'b0);
		pulse(8'h80);
		rd(`UIFC_OFF_ISR, 32'hD0);
		rd(`UIFC_OFF_ISR, 32'hC1);
		pulse(8'h80);
		pulse(8'h10);
		rd(`UIFC_OFF_ISR, 32'hC1);
		auto_cts_en <= 1'b1;
		cts_n <= 1'b1;
		settle();
		rd(`UIFC_OFF_ISR, 32'hE0);
		pulse(8'h04);
		rd(`UIFC_OFF_ISR, 32'hC1);
		auto_rts_en <= 1'b1;
		rts_n <= 1'b1;
		settle();
		rd(`UIFC_OFF_ISR, 32'hE0);
		pulse(8'h04);
		rd(`UIFC_OFF_ISR, 32'hC1);
		wr(`UIFC_OFF_IER, 32'h00);
		modem_status_delta <= 4'h1;
		@(posedge clk) modem_status_delta <= 4'h0;
		settle();
		chk(irq, 1'b0);
		finish_test();
	end
endmodule

// ### testbench/uifc_host_model.sv
// host processor model: an apb master that reaches the interrupt/fifo control registers
// assumes one rising-edge clock shared with the slave; waits on pready are bounded
module uifc_host_model (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	`include "uifc_cfg.svh"
	logic hung;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		hung = 1'b0;
	end

	// request held from setup until the edge that samples pready high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
			hung = 1'b1;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// enable bit always sent along, otherwise the other bits are dropped
	task automatic fifo_control(input logic [7:0] v);
		logic [31:0] r;
		logic e;
		xfer(1'b1, `UIFC_OFF_FCR, {24'h0, v | 8'h01}, r, e);
	endtask
endmodule
